// file: irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // Main control register field positions
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PGE_BIT = 6;
  localparam int TIE_BIT = 5;
  localparam int EIE_BIT = 4;
  localparam int CIE_BIT = 3;
  localparam int TIF_BIT = 2;
  localparam int EIF_BIT = 1;
  localparam int CIF_BIT = 0;
  localparam int EDGE_SEL_BIT = 6;
  // Three main sources, seven in group a and one in group b: eleven in all
  localparam int NUM_PERIPH = 7;
  localparam int NUM_PERIPH_B = 1;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Flops in the synchroniser chain (meta, sync) ahead of the edge detector
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } cpu_state_e;
endpackage

// file: edge_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rising/falling edge detection
module edge_sync
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic rise_sel_i,
  output logic edge_o
);
  logic meta;
  logic sync;
  logic last;

  // Synchroniser chain and edge history
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  // Edge of the chosen polarity
  always_comb
  begin
    edge_o = rise_sel_i ? (sync & ~last) : (~sync & last);
  end
endmodule

// file: mcu_interrupt_control.sv
`timescale 1ns/1ps
module mcu_interrupt_control
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_PA = NUM_PERIPH,
  parameter int NUM_PB = NUM_PERIPH_B
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ext_irq_pin_i,
  input wire logic [3:0] port_change_pins_i,
  input wire logic [7:0] timer_zero_count_i,
  input wire logic ext_edge_select_i,
  input wire logic [NUM_PA-1:0] periph_event_a_i,
  input wire logic [NUM_PB-1:0] periph_event_b_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic flag_a_wr_i,
  input wire logic [NUM_PA-1:0] flag_a_wdata_i,
  input wire logic flag_b_wr_i,
  input wire logic [NUM_PB-1:0] flag_b_wdata_i,
  input wire logic mask_a_wr_i,
  input wire logic [NUM_PA-1:0] mask_a_wdata_i,
  input wire logic mask_b_wr_i,
  input wire logic [NUM_PB-1:0] mask_b_wdata_i,
  input wire logic instr_end_i,
  input wire logic return_from_irq_instr_i,
  input wire logic sleep_i,
  output logic [7:0] main_irq_control_reg_o,
  output logic [NUM_PA-1:0] periph_flag_reg_a_o,
  output logic [NUM_PB-1:0] periph_flag_reg_b_o,
  output logic [NUM_PA-1:0] periph_mask_reg_a_o,
  output logic [NUM_PB-1:0] periph_mask_reg_b_o,
  output logic irq_req_o,
  output logic vector_take_o,
  output logic [12:0] vector_addr_o,
  output logic wake_o,
  output logic sleeping_o
);
  logic [7:0] ctrl;
  logic [NUM_PA-1:0] flag_a;
  logic [NUM_PB-1:0] flag_b;
  logic [NUM_PA-1:0] mask_a;
  logic [NUM_PB-1:0] mask_b;
  logic ext_edge;
  logic [3:0] chg_meta;
  logic [3:0] chg_sync;
  logic [3:0] chg_last;
  logic chg_event;
  logic [7:0] tmr_last;
  logic tmr_ovf;
  logic periph_any;
  logic pending;
  logic accept;
  logic enable_clr_wr;
  logic wake_ev;
  cpu_state_e state;
  cpu_state_e next_state;

  // External pin edge detector, synchronised
  edge_sync u_ext_edge (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(ext_irq_pin_i),
    .rise_sel_i(ext_edge_select_i),
    .edge_o(ext_edge)
  );

  // Port change detector and timer history
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      chg_meta <= 4'h0;
      chg_sync <= 4'h0;
      chg_last <= 4'h0;
      tmr_last <= TIMER_ZERO;
    end
    else
    begin
      chg_meta <= port_change_pins_i;
      chg_sync <= chg_meta;
      chg_last <= chg_sync;
      tmr_last <= timer_zero_count_i;
    end
  end

  assign chg_event = |(chg_sync ^ chg_last);
  assign tmr_ovf = (tmr_last == TIMER_MAX) && (timer_zero_count_i == TIMER_ZERO);

  // Source products and gated request
  assign periph_any = |(flag_a & mask_a) | |(flag_b & mask_b);
  assign pending = (ctrl[TIF_BIT] & ctrl[TIE_BIT]) | (ctrl[EIF_BIT] & ctrl[EIE_BIT])
    | (ctrl[CIF_BIT] & ctrl[CIE_BIT]) | (periph_any & ctrl[PGE_BIT]);
  // A write clearing the enable blocks acceptance, so a later return cannot re-enable by surprise
  assign enable_clr_wr = ctrl_wr_i && !ctrl_wdata_i[GLOBAL_IRQ_ENABLE_BIT];
  // Acceptance only at an instruction boundary while running with enable set
  assign accept = ctrl[GLOBAL_IRQ_ENABLE_BIT] && pending && instr_end_i && (state == ST_RUN)
    && !enable_clr_wr;
  assign wake_ev = pending && (state == ST_SLEEP);

  // Main control register: enables, flags, global enable
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      ctrl <= CTRL_RESET;
    else
    begin
      if (ctrl_wr_i)
        ctrl <= ctrl_wdata_i;
      // Hardware sets win over software writes
      if (ext_edge)
        ctrl[EIF_BIT] <= 1'b1;
      if (chg_event)
        ctrl[CIF_BIT] <= 1'b1;
      if (tmr_ovf)
        ctrl[TIF_BIT] <= 1'b1;
      // Acceptance beats a return or a write on the enable
      if (accept)
        ctrl[GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
      else if (return_from_irq_instr_i)
        ctrl[GLOBAL_IRQ_ENABLE_BIT] <= 1'b1;
    end
  end

  // Peripheral flags: set wins over write
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      flag_a <= '0;
      flag_b <= '0;
    end
    else
    begin
      flag_a <= (flag_a_wr_i ? flag_a_wdata_i : flag_a) | periph_event_a_i;
      flag_b <= (flag_b_wr_i ? flag_b_wdata_i : flag_b) | periph_event_b_i;
    end
  end

  // Peripheral masks
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      mask_a <= '0;
      mask_b <= '0;
    end
    else
    begin
      if (mask_a_wr_i)
        mask_a <= mask_a_wdata_i;
      if (mask_b_wr_i)
        mask_b <= mask_b_wdata_i;
    end
  end

  // Sleep sequencer: on wake run PC+1 before vectoring
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RUN: if (sleep_i) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_ev) next_state = ST_WAKE;
      ST_WAKE: if (instr_end_i) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // Registered outputs to the core
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      irq_req_o <= 1'b0;
      vector_take_o <= 1'b0;
      vector_addr_o <= IRQ_VECTOR;
      wake_o <= 1'b0;
      sleeping_o <= 1'b0;
    end
    else
    begin
      irq_req_o <= pending & ctrl[GLOBAL_IRQ_ENABLE_BIT];
      vector_take_o <= accept;
      vector_addr_o <= IRQ_VECTOR;
      wake_o <= wake_ev;
      sleeping_o <= (next_state == ST_SLEEP);
    end
  end

  // Register views
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      main_irq_control_reg_o <= CTRL_RESET;
      periph_flag_reg_a_o <= '0;
      periph_flag_reg_b_o <= '0;
      periph_mask_reg_a_o <= '0;
      periph_mask_reg_b_o <= '0;
    end
    else
    begin
      main_irq_control_reg_o <= ctrl;
      periph_flag_reg_a_o <= flag_a;
      periph_flag_reg_b_o <= flag_b;
      periph_mask_reg_a_o <= mask_a;
      periph_mask_reg_b_o <= mask_b;
    end
  end

  // Checks
  glb_reset_a: assert property (@(posedge ref_clk_i) !rstn_i |=> !ctrl[GLOBAL_IRQ_ENABLE_BIT])
    else $error("enable not cleared by reset");
  accept_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    accept |=> !ctrl[GLOBAL_IRQ_ENABLE_BIT])
    else $error("enable kept after accept");
  reti_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    return_from_irq_instr_i && !accept |=> ctrl[GLOBAL_IRQ_ENABLE_BIT])
    else $error("return did not enable");
  take_out_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) accept |=> vector_take_o)
    else $error("vector not taken");
  no_enable_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !ctrl[GLOBAL_IRQ_ENABLE_BIT] |=> !vector_take_o)
    else $error("vector without enable");
  clr_race_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_wr_i && !ctrl_wdata_i[GLOBAL_IRQ_ENABLE_BIT] |=> !vector_take_o)
    else $error("vector taken while enable cleared");
  tmr_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) tmr_ovf |=> ctrl[TIF_BIT])
    else $error("overflow flag missed");
  ext_lat_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(ext_irq_pin_i) && ext_edge_select_i ##1 (ext_edge_select_i && !ctrl_wr_i)[*2] |=> ctrl[EIF_BIT])
    else $error("pin flag late");
  per_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    |periph_event_a_i |=> |flag_a)
    else $error("peripheral flag missed");
  wake_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) wake_o |-> pending)
    else $error("wake without flag");
  req_or_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    irq_req_o |-> $past(ctrl[GLOBAL_IRQ_ENABLE_BIT]))
    else $error("request without enable");
  accept_c: cover property (@(posedge ref_clk_i) accept);
  wake_c: cover property (@(posedge ref_clk_i) state == ST_WAKE ##1 state == ST_RUN);
  reti_c: cover property (@(posedge ref_clk_i) vector_take_o ##[1:20] return_from_irq_instr_i);
endmodule

// file: core_model.sv
`timescale 1ns/1ps
// Core sequencer at the far side: instruction boundaries and vector pushes
module core_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic sleeping_i,
  input wire logic vector_take_i,
  output logic instr_end_o,
  output logic [7:0] take_count_o
);
  // One boundary per cycle while awake; halted core marks none
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      instr_end_o <= 1'b0;
      take_count_o <= 8'h00;
    end
    else
    begin
      instr_end_o <= !sleeping_i;
      take_count_o <= take_count_o + {7'h00, vector_take_i};
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb
  import irq_ctrl_pkg::*;
();
  logic clk, rstn, pin, esel, ret, slp, evb, req, take, wk, slpg, iend;
  logic [4:0] wrs;
  logic [3:0] chg;
  logic [7:0] tmr, wd, ctl, tc, w;
  logic [6:0] eva, fa, ma;
  logic [0:0] fb, mb;
  logic [12:0] vad;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  int cyc = 0;
  int tw = 0;
  int tt = 0;
  int tr = 0;

  mcu_interrupt_control mcu_interrupt_control_inst (
    .ref_clk_i(clk), .rstn_i(rstn), .ext_irq_pin_i(pin), .port_change_pins_i(chg),
    .timer_zero_count_i(tmr), .ext_edge_select_i(esel), .periph_event_a_i(eva),
    .periph_event_b_i(evb), .ctrl_wr_i(wrs[4]), .ctrl_wdata_i(wd), .flag_a_wr_i(wrs[3]),
    .flag_a_wdata_i(wd[6:0]), .flag_b_wr_i(wrs[2]), .flag_b_wdata_i(wd[0:0]), .mask_a_wr_i(wrs[1]),
    .mask_a_wdata_i(wd[6:0]), .mask_b_wr_i(wrs[0]), .mask_b_wdata_i(wd[0:0]), .instr_end_i(iend),
    .return_from_irq_instr_i(ret), .sleep_i(slp), .main_irq_control_reg_o(ctl),
    .periph_flag_reg_a_o(fa), .periph_flag_reg_b_o(fb), .periph_mask_reg_a_o(ma),
    .periph_mask_reg_b_o(mb), .irq_req_o(req), .vector_take_o(take), .vector_addr_o(vad),
    .wake_o(wk), .sleeping_o(slpg));

  core_model core_model_inst (.ref_clk_i(clk), .rstn_i(rstn), .sleeping_i(slpg),
    .vector_take_i(take), .instr_end_o(iend), .take_count_o(tc));

  // Clock at 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle stamps of the last wake and the last vector
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wk === 1'b1) tw <= cyc;
    if (take === 1'b1) tt <= cyc;
    if (req === 1'b1) tr <= cyc;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe: 0 main, 1 flag a, 2 flag b, 3 mask a, 4 mask b
  task automatic wr(input int s, input logic [7:0] v);
    @(posedge clk);
    wrs <= 5'b10000 >> s;
    wd <= v;
    @(posedge clk);
    wrs <= 5'b00000;
    tick(1);
  endtask

  // One-cycle pulses: events a, then {event b, return, sleep}
  task automatic pulse(input logic [6:0] a, input logic [2:0] k);
    @(posedge clk);
    eva <= a;
    {evb, ret, slp} <= k;
    @(posedge clk);
    eva <= 7'h00;
    {evb, ret, slp} <= 3'b000;
    tick(1);
  endtask

  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    chk(ctl, CTRL_RESET);
    chk(vad, IRQ_VECTOR);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: the tests need well under 1000 cycles
  initial
  begin
    #20000;
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    {rstn, pin, esel, ret, slp, evb, wrs, chg, tmr, wd, eva} = '0;
    rst();
    $display("test reset done");
    pulse(7'h41, 3'b100);
    chk(fa, 7'h41);
    chk(fb, 1'b1);
    chk(req, 1'b0);
    wr(2, 8'h00);
    chk(fb, 1'b0);
    wr(4, 8'h01);
    chk(mb, 1'b1);
    wr(3, 8'h40);
    chk(ma, 7'h40);
    wr(0, 8'h80);
    tick(4);
    chk(req, 1'b0);
    chk(tc, 8'h00);
    $display("test flags done");
    w = tc;
    wr(0, 8'hC0);
    tick(8);
    chk(tc, w + 8'h01);
    chk(ctl, 8'h40);
    chk(16'(tr), 16'(tt));
    pulse(7'h00, 3'b010);
    tick(8);
    chk(tc, w + 8'h02);
    chk(16'(tr), 16'(tt));
    wr(1, 8'h00);
    pulse(7'h00, 3'b010);
    tick(8);
    chk(tc, w + 8'h02);
    chk(ctl, 8'hC0);
    // A write clearing the enable meets a fresh request: nothing may be taken
    @(posedge clk);
    eva <= 7'h40;
    @(posedge clk);
    eva <= 7'h00;
    wrs <= 5'b10000;
    wd <= 8'h40;
    @(posedge clk);
    wrs <= 5'b00000;
    tick(4);
    chk(tc, w + 8'h02);
    chk(ctl, 8'h40);
    rst();
    $display("test accept done");
    for (int i = 0; i < 2; i++)
    begin
      wr(0, 8'h90);
      @(posedge clk);
      esel <= ~i[0];
      pin <= ~i[0];
      n = 0;
      while (take !== 1'b1 && n < 12)
      begin
        tick(1);
        n++;
      end
      chk(n >= 3 && n <= 4, 1'b1);
      tick(2);
      chk(ctl, 8'h12);
    end
    wr(0, 8'h10);
    @(posedge clk);
    pin <= 1'b1;
    tick(6);
    chk(ctl, 8'h10);
    $display("test pin done");
    wr(0, 8'h00);
    @(posedge clk);
    tmr <= 8'hFE;
    @(posedge clk);
    tmr <= TIMER_MAX;
    tick(2);
    chk(ctl, 8'h00);
    @(posedge clk);
    tmr <= TIMER_ZERO;
    tick(2);
    chk(ctl, 8'h04);
    @(posedge clk);
    chg <= 4'h8;
    tick(6);
    chk(ctl, 8'h05);
    $display("test timer done");
    wr(3, 8'h40);
    wr(0, 8'hC0);
    pulse(7'h00, 3'b001);
    tick(2);
    chk(slpg, 1'b1);
    w = tc;
    pulse(7'h40, 3'b000);
    tick(8);
    chk(tc, w + 8'h01);
    chk(tt >= tw + 2, 1'b1);
    chk(fa, 7'h40);
    chk(ctl, 8'h40);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule
